// ===== sim/hisel_spi_master.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host side spi master, mode 0, timed in whole core periods
// ----------------------------------------------------------------
module hisel_spi_master #(
   parameter int HALF_NS = 100
) (
   output logic      sck,
   output logic      mosi,
   output logic      nss_n,
   input  wire logic miso
);
   // clock rests low and select high outside frames
   initial
   begin
      sck   = 1'b0;
      mosi  = 1'b0;
      nss_n = 1'b1;
   end

   // select low over a whole transfer, high for a gap between transfers
   task automatic select(input logic on);
      if (on)
      begin
         nss_n = 1'b0;
         #(HALF_NS);
      end
      else
      begin
         #(HALF_NS);
         nss_n = 1'b1;
         mosi  = ~mosi; // released line must not keep its last value
         #(HALF_NS);
      end
   endtask

   // shift nbits msb first; data moves only while the clock is low
   task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--)
      begin
         mosi = tx[i];
         #(HALF_NS);
         sck   = 1'b1;
         rx[i] = miso; // sampled at the rising edge
         #(HALF_NS);
         sck = 1'b0;
      end
   endtask
endmodule // hisel_spi_master

// ===== sim/test_hisel_spi_slave.sv
`timescale 1ns/1ps

module test_hisel_spi_slave;
   localparam int         COLD = 4;
   localparam logic [6:0] FIFO = 7'h05;
   logic                   core_clk, rst_n, power_down, strap_lo, strap_hi, uart_tx, sda_low;
   logic                   sck, mosi, nss_n, pin_c, pin_d, c_out, c_oe, d_out, d_oe;
   logic                   u_rx, tw_scl, tw_a1, tw_a2, tw_sda;
   hisel_pkg::hisel_mode_t iface_mode;
   logic                   iface_ready, rd_req, wr_valid, wr_ready, wr_space, wr_overrun;
   logic [6:0]             rd_addr, wr_addr;
   logic [7:0]             rd_data, wr_data;
   logic [7:0]             rx[$];
   logic [14:0]            words[$];
   int                     errors, num_checks, reads;

   // ----------------------------------------------------------------
   // wires, pull-up on the shared data pin, register file stand-in
   // ----------------------------------------------------------------
   assign pin_c   = c_oe ? c_out : 1'b1;
   assign pin_d   = d_oe ? d_out : nss_n;
   assign rd_data = {rd_addr, 1'b0} ^ 8'h5a;

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   hisel_spi_master i_hisel_spi_master (.sck(sck), .mosi(mosi), .nss_n(nss_n), .miso(pin_c));

   hisel_spi_slave #(.COLD_CYCLES(COLD), .FIFO_ADDR(FIFO)) i_hisel_spi_slave (
      .core_clk(core_clk), .rst_n(rst_n), .power_down(power_down),
      .iface_strap_lo(strap_lo), .iface_strap_hi(strap_hi),
      .shared_pin_a(mosi), .shared_pin_b(sck),
      .shared_pin_c_in(pin_c), .shared_pin_c_out(c_out), .shared_pin_c_oe(c_oe),
      .shared_pin_d_in(pin_d), .shared_pin_d_out(d_out), .shared_pin_d_oe(d_oe),
      .iface_mode(iface_mode), .iface_ready(iface_ready), .uart_rx(u_rx), .uart_tx(uart_tx),
      .twowire_scl(tw_scl), .twowire_addr_bit1(tw_a1), .twowire_addr_bit2(tw_a2), .twowire_sda_in(tw_sda),
      .twowire_sda_low(sda_low), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_space(wr_space), .wr_overrun(wr_overrun));

   // words taken from the buffer and read strobes seen
   always @(posedge core_clk)
   begin
      if (wr_valid === 1'b1 && wr_ready === 1'b1)
         words.push_back({wr_addr, wr_data});
      if (rd_req === 1'b1)
         reads++;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // counts cycles to ready; a hang ends the run
   task automatic wait_ready(output int n);
      for (n = 0; n < 200 && iface_ready !== 1'b1; n++)
         @(negedge core_clk);
      if (n >= 200)
      begin
         errors++;
         complete_run();
      end
   endtask

   task automatic wait_words(input int cnt);
      int n;
      for (n = 0; n < 400 && words.size() < cnt; n++)
         @(negedge core_clk);
      if (n >= 400)
      begin
         errors++;
         complete_run();
      end
   endtask

   // one whole transfer of full bytes under one selection
   task automatic frame(input logic [7:0] tx[$]);
      logic [7:0] r;
      rx = {};
      @(negedge core_clk);
      i_hisel_spi_master.select(1'b1);
      foreach (tx[i])
      begin
         i_hisel_spi_master.shift(tx[i], 8, r);
         rx.push_back(r);
      end
      i_hisel_spi_master.select(1'b0);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_boot;
      int n;
      wait_ready(n);
      check("boot cycles", 16'(n >= COLD && n <= COLD + 3), 16'h0001);
      check("mode", 16'(iface_mode), 16'(hisel_pkg::HISEL_MODE_SPI));
      check("miso oe idle", 16'(c_oe), 16'h0000);
      strap_hi = 1'b0;
      repeat (6) @(negedge core_clk);
      check("mode after strap move", 16'(iface_mode), 16'(hisel_pkg::HISEL_MODE_SPI));
      strap_hi = 1'b1;
   endtask

   task automatic t_write;
      logic [7:0] d[$] = '{8'h20, 8'ha5, 8'h3c, 8'h81};
      words = {};
      frame(d);
      wait_words(3);
      check("write words", 16'(words.size()), 16'h0003);
      foreach (words[i])
         check("write word", 16'(words[i]), 16'({7'h10 + 7'(i), d[i + 1]}));
      foreach (rx[i])
         check("miso in write", 16'(rx[i]), 16'h0000);
   endtask

   task automatic t_read;
      reads = 0;
      frame('{8'h63, 8'h0b, 8'h00});
      check("read slot 1", 16'(rx[1]), 16'({7'h31, 1'b0} ^ 8'h5a));
      check("read slot 2", 16'(rx[2]), 16'({7'h05, 1'b0} ^ 8'h5a));
      check("read strobes", 16'(reads), 16'h0002);
   endtask

   task automatic t_fifo_stall;
      words    = {};
      wr_ready = 1'b0;
      frame('{{FIFO, 1'b0}, 8'h11, 8'h22, 8'h33});
      check("space when full", 16'(wr_space), 16'h0000);
      check("overrun", 16'(wr_overrun), 16'h0001);
      wr_ready = 1'b1;
      wait_words(2);
      repeat (4) @(negedge core_clk);
      check("fifo words", 16'(words.size()), 16'h0002);
      check("fifo word 0", 16'(words[0]), 16'({FIFO, 8'h11}));
      check("fifo word 1", 16'(words[1]), 16'({FIFO, 8'h22}));
      check("drained", 16'(wr_valid), 16'h0000);
      check("space after drain", 16'(wr_space), 16'h0001);
   endtask

   task automatic t_abort;
      logic [7:0] r;
      words = {};
      @(negedge core_clk);
      i_hisel_spi_master.select(1'b1);
      i_hisel_spi_master.shift(8'h40, 4, r);
      i_hisel_spi_master.select(1'b0);
      frame('{8'h2e, 8'hc3});
      wait_words(1);
      repeat (4) @(negedge core_clk);
      check("words after abort", 16'(words.size()), 16'h0001);
      check("word after abort", 16'(words[0]), 16'({7'h17, 8'hc3}));
   endtask

   // every strap code through a power-down exit
   task automatic t_modes;
      int n;
      sda_low = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         power_down = 1'b1;
         {strap_hi, strap_lo} = 2'(m);
         // pin a level differs from the idle clock on odd codes, so the routes can be told apart
         i_hisel_spi_master.mosi = m[0];
         repeat (4) @(negedge core_clk);
         check("ready in power down", 16'(iface_ready), 16'h0000);
         power_down = 1'b0;
         wait_ready(n);
         repeat (3) @(negedge core_clk);
         check("mode code", 16'(iface_mode), 16'(m));
         check("pin c level", 16'(pin_c), 16'(m == 1 || m == 2));
         check("pin d drive", 16'(d_oe), 16'(m == 1));
         check("uart rx route", 16'(u_rx), 16'(mosi));
         check("scl route", 16'(tw_scl), 16'(sck));
         check("addr bit1 route", 16'(tw_a1), 16'(mosi));
         check("addr bit2 route", 16'(tw_a2), 16'(m == 1 ? pin_c : pin_d));
         check("sda route", 16'(tw_sda), 16'(m == 1 ? pin_d : pin_c));
         check("overrun cleared", 16'(wr_overrun), 16'h0000);
      end
   endtask

   initial
   begin
      rst_n      = 1'b0;
      power_down = 1'b0;
      strap_hi   = 1'b1;
      strap_lo   = 1'b0;
      uart_tx    = 1'b0;
      sda_low    = 1'b0;
      wr_ready   = 1'b1;
      errors     = 0;
      num_checks = 0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      t_boot();
      repeat (3) @(negedge core_clk);
      t_write();
      t_read();
      t_fifo_stall();
      t_abort();
      t_modes();
      complete_run();
   end
endmodule // test_hisel_spi_slave

// ===== verilog/hisel_buf.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// small valid/ready buffer for write words
// ----------------------------------------------------------------
module hisel_buf #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 2
) (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW:0]      count;
   wire              push;
   wire              pop;

   function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
      ptr_step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // full and empty come straight from the occupancy count
   assign in_ready  = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage needs no reset, only the pointers and the count do
   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= ptr_step(wr_ptr);
         end
         if (pop)
         begin
            rd_ptr <= ptr_step(rd_ptr);
         end
         if (push != pop)
         begin
            count <= push ? (PW+1)'(count + 1'b1) : (PW+1)'(count - 1'b1);
         end
      end
   end

endmodule // hisel_buf

// ===== verilog/hisel_pkg.sv
package hisel_pkg;

   // ----------------------------------------------------------------
   // interface type, coded as {iface_strap_hi, iface_strap_lo}
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      HISEL_MODE_UART        = 2'h0,
      HISEL_MODE_TWOWIRE     = 2'h1,
      HISEL_MODE_SPI         = 2'h2,
      HISEL_MODE_ALT_TWOWIRE = 2'h3
   } hisel_mode_t;

   // ----------------------------------------------------------------
   // start-up sequencer and spi byte phase
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      HISEL_BOOT_COLD  = 3'h1,
      HISEL_BOOT_LATCH = 3'h2,
      HISEL_BOOT_RUN   = 3'h4
   } hisel_boot_t;

   typedef enum logic [3:0] {
      HISEL_PH_IDLE  = 4'h1,
      HISEL_PH_ADDR  = 4'h2,
      HISEL_PH_WRITE = 4'h4,
      HISEL_PH_READ  = 4'h8
   } hisel_phase_t;

endpackage

// ===== verilog/hisel_regs.svh
`ifndef HISEL_REGS_SVH
`define HISEL_REGS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define HISEL_CLK_MHZ        40
// cold reset phase length in ns, then rounded up to whole cycles
`define HISEL_COLD_NS        1000
`define HISEL_COLD_CYCLES    ((`HISEL_COLD_NS * `HISEL_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// address byte layout and special addresses
// ----------------------------------------------------------------
`define HISEL_ADDR_W         7
`define HISEL_BYTE_W         8
`define HISEL_RW_BIT         0
`define HISEL_RW_READ        1'b1
`define HISEL_FIFO_ADDR      7'h05

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define HISEL_RST_BYTE       8'h00
`define HISEL_RST_ADDR       7'h00
`define HISEL_RST_BITCNT     3'h0
`define HISEL_LAST_BIT       3'h7

`endif

// ===== verilog/hisel_spi_slave.sv
`timescale 1ns/1ps
`include "hisel_regs.svh"

module hisel_spi_slave #(
   parameter int         COLD_CYCLES = `HISEL_COLD_CYCLES,
   parameter logic [6:0] FIFO_ADDR   = `HISEL_FIFO_ADDR,
   parameter int         BUF_DEPTH   = 2
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire logic                 power_down,
   input  wire logic                 iface_strap_lo,
   input  wire logic                 iface_strap_hi,
   input  wire logic                 shared_pin_a,
   input  wire logic                 shared_pin_b,
   input  wire logic                 shared_pin_c_in,
   output logic                      shared_pin_c_out,
   output logic                      shared_pin_c_oe,
   input  wire logic                 shared_pin_d_in,
   output logic                      shared_pin_d_out,
   output logic                      shared_pin_d_oe,
   output hisel_pkg::hisel_mode_t    iface_mode,
   output logic                      iface_ready,
   output logic                      uart_rx,
   input  wire logic                 uart_tx,
   output logic                      twowire_scl,
   output logic                      twowire_addr_bit1,
   output logic                      twowire_addr_bit2,
   output logic                      twowire_sda_in,
   input  wire logic                 twowire_sda_low,
   output logic                      rd_req,
   output logic [`HISEL_ADDR_W-1:0]  rd_addr,
   input  wire logic [`HISEL_BYTE_W-1:0] rd_data,
   output logic                      wr_valid,
   input  wire logic                 wr_ready,
   output logic [`HISEL_ADDR_W-1:0]  wr_addr,
   output logic [`HISEL_BYTE_W-1:0]  wr_data,
   output logic                      wr_space,
   output logic                      wr_overrun
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int S_A  = 0;
   localparam int S_B  = 1;
   localparam int S_C  = 2;
   localparam int S_D  = 3;
   localparam int S_LO = 4;
   localparam int S_HI = 5;
   localparam int AW   = `HISEL_ADDR_W;
   localparam int BW   = `HISEL_BYTE_W;

   logic [5:0]                sync1;
   logic [5:0]                sync2;
   logic                      sck_q;
   hisel_pkg::hisel_boot_t    boot;
   hisel_pkg::hisel_boot_t    next_boot;
   logic [15:0]               cold_cnt;
   hisel_pkg::hisel_phase_t   phase;
   logic [2:0]                bit_cnt;
   logic                      seen_rise;
   logic [BW-1:0]             rx_shift;
   logic [BW-1:0]             tx_byte;
   logic                      miso;
   logic [AW-1:0]             wr_ptr;

   // two flops on every pin; at 40 MHz a 10 Mbit/s bit still spans four samples
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sck_q <= 1'b0;
      end
      else
      begin
         sync1 <= {iface_strap_hi, iface_strap_lo, shared_pin_d_in, shared_pin_c_in, shared_pin_b, shared_pin_a};
         sync2 <= sync1;
         sck_q <= sync2[S_B];
      end
   end

   // ----------------------------------------------------------------
   // start-up: cold phase, strap latch, run
   // ----------------------------------------------------------------
   wire [1:0] strap_sync = {sync2[S_HI], sync2[S_LO]};
   wire       cold_done  = (cold_cnt == 16'(COLD_CYCLES - 1));

   // power-down drops back to the cold phase, so the type is found again on exit
   always_comb
   begin
      next_boot = boot;
      case (boot)
         hisel_pkg::HISEL_BOOT_COLD:  next_boot = (!power_down && cold_done) ? hisel_pkg::HISEL_BOOT_LATCH : boot;
         hisel_pkg::HISEL_BOOT_LATCH: next_boot = power_down ? hisel_pkg::HISEL_BOOT_COLD : hisel_pkg::HISEL_BOOT_RUN;
         hisel_pkg::HISEL_BOOT_RUN:   next_boot = power_down ? hisel_pkg::HISEL_BOOT_COLD : boot;
         default:                     next_boot = hisel_pkg::HISEL_BOOT_COLD;
      endcase
   end

   // straps are read once per start-up, in the single latch cycle after the cold phase
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         boot       <= hisel_pkg::HISEL_BOOT_COLD;
         cold_cnt   <= 16'h0000;
         iface_mode <= hisel_pkg::HISEL_MODE_UART;
      end
      else
      begin
         boot     <= next_boot;
         cold_cnt <= (boot != hisel_pkg::HISEL_BOOT_COLD || power_down) ? 16'h0000 : 16'(cold_cnt + 1'b1);
         if (boot == hisel_pkg::HISEL_BOOT_LATCH && !power_down)
         begin
            iface_mode <= hisel_pkg::hisel_mode_t'(strap_sync);
         end
      end
   end

   assign iface_ready = (boot == hisel_pkg::HISEL_BOOT_RUN);

   // ----------------------------------------------------------------
   // pin roles per interface type
   // ----------------------------------------------------------------
   wire is_spi  = iface_ready && (iface_mode == hisel_pkg::HISEL_MODE_SPI);
   wire is_uart = iface_ready && (iface_mode == hisel_pkg::HISEL_MODE_UART);
   wire is_std  = iface_ready && (iface_mode == hisel_pkg::HISEL_MODE_TWOWIRE);
   wire is_alt  = iface_ready && (iface_mode == hisel_pkg::HISEL_MODE_ALT_TWOWIRE);
   wire nss_n   = sync2[S_D];
   wire mosi    = sync2[S_A];
   wire sck     = sync2[S_B];

   // routes toward the engines that live outside this block
   assign uart_rx           = sync2[S_A];
   assign twowire_scl       = sync2[S_B];
   assign twowire_addr_bit1 = sync2[S_A];
   assign twowire_addr_bit2 = is_std ? sync2[S_C] : sync2[S_D];
   assign twowire_sda_in    = is_std ? sync2[S_D] : sync2[S_C];

   // pin b is the serial clock in spi mode and has no driver at all
   assign shared_pin_c_out = is_spi ? miso : (is_uart ? uart_tx : 1'b0);
   assign shared_pin_c_oe  = (is_spi && !nss_n) || is_uart || (is_alt && twowire_sda_low);
   assign shared_pin_d_out = 1'b0;
   assign shared_pin_d_oe  = is_std && twowire_sda_low;

   // ----------------------------------------------------------------
   // spi edge detection and byte assembly
   // ----------------------------------------------------------------
   wire              selected  = is_spi && !nss_n;
   wire              sck_rise  = selected && sck && !sck_q;
   wire              sck_fall  = selected && !sck && sck_q && seen_rise;
   wire              byte_done = sck_rise && (bit_cnt == `HISEL_LAST_BIT);
   wire [BW-1:0]     rx_byte   = {rx_shift[BW-2:0], mosi};
   wire              rw_read   = (rx_byte[`HISEL_RW_BIT] == `HISEL_RW_READ);
   wire [AW-1:0]     byte_addr = rx_byte[BW-1:1];
   wire              addr_slot = (phase == hisel_pkg::HISEL_PH_ADDR) || (phase == hisel_pkg::HISEL_PH_READ);
   wire              rd_hit    = byte_done && addr_slot && rw_read;
   wire              push      = byte_done && (phase == hisel_pkg::HISEL_PH_WRITE);
   wire              buf_ready;

   // phase walks idle, address, then read or write until select rises
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase     <= hisel_pkg::HISEL_PH_IDLE;
         bit_cnt   <= `HISEL_RST_BITCNT;
         seen_rise <= 1'b0;
         rx_shift  <= `HISEL_RST_BYTE;
      end
      else if (!selected)
      begin
         phase     <= hisel_pkg::HISEL_PH_IDLE;
         bit_cnt   <= `HISEL_RST_BITCNT;
         seen_rise <= 1'b0;
      end
      else
      begin
         if (phase == hisel_pkg::HISEL_PH_IDLE)
         begin
            phase <= hisel_pkg::HISEL_PH_ADDR;
         end
         if (sck_rise)
         begin
            rx_shift  <= rx_byte;
            bit_cnt   <= 3'(bit_cnt + 1'b1);
            seen_rise <= 1'b1;
         end
         if (byte_done && phase == hisel_pkg::HISEL_PH_ADDR)
         begin
            phase <= rw_read ? hisel_pkg::HISEL_PH_READ : hisel_pkg::HISEL_PH_WRITE;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path: one slot of latency between address and data
   // ----------------------------------------------------------------
   // rd_data is taken in the rd_req cycle, which lands before the earliest falling edge
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_req  <= 1'b0;
         rd_addr <= `HISEL_RST_ADDR;
         tx_byte <= `HISEL_RST_BYTE;
         miso    <= 1'b0;
      end
      else
      begin
         rd_req <= rd_hit;
         if (rd_hit)
         begin
            rd_addr <= byte_addr;
         end
         if (!selected)
         begin
            tx_byte <= `HISEL_RST_BYTE;
            miso    <= 1'b0;
         end
         else
         begin
            if (rd_req)
            begin
               tx_byte <= rd_data;
            end
            else if (byte_done && !rd_hit)
            begin
               tx_byte <= `HISEL_RST_BYTE;
            end
            if (sck_fall)
            begin
               miso <= tx_byte[~bit_cnt];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // write path: address pointer and buffered words
   // ----------------------------------------------------------------
   // the link cannot be stalled, so a full buffer drops the byte and flags it
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr     <= `HISEL_RST_ADDR;
         wr_overrun <= 1'b0;
      end
      else
      begin
         if (byte_done && phase == hisel_pkg::HISEL_PH_ADDR)
         begin
            wr_ptr <= byte_addr;
         end
         else if (push && wr_ptr != FIFO_ADDR)
         begin
            wr_ptr <= AW'(wr_ptr + 1'b1);
         end
         if (push && !buf_ready)
         begin
            wr_overrun <= 1'b1;
         end
         else if (power_down)
         begin
            wr_overrun <= 1'b0;
         end
      end
   end

   assign wr_space = buf_ready;

   hisel_buf #(
      .WIDTH (AW + BW),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   ({wr_ptr, rx_byte}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  ({wr_addr, wr_data})
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_read_addr;
      rd_hit;
   endsequence

   sequence s_push_inc;
      push && (wr_ptr != FIFO_ADDR);
   endsequence

   AST_PD_RESET: assert property (power_down |=> !iface_ready ##1 !iface_ready)
      else $error("interface stayed ready through power-down");
   AST_MODE_HOLD: assert property ((iface_ready && !power_down) |=> $stable(iface_mode))
      else $error("interface type changed after start-up");
   AST_DECODE: assert property ((boot == hisel_pkg::HISEL_BOOT_LATCH && !power_down)
         |=> iface_ready && (iface_mode == hisel_pkg::hisel_mode_t'($past(strap_sync))))
      else $error("strap decode mismatch");
   AST_NO_DRIVE_DESEL: assert property ((is_spi && nss_n) |-> !shared_pin_c_oe)
      else $error("data pin driven while not selected");
   AST_MISO_FALL_ONLY: assert property ((selected && !$rose(sck_fall)) ##1 (selected && !sck_fall)
         |-> $stable(miso))
      else $error("MISO moved without a falling edge");
   AST_READ_ADDR: assert property (s_read_addr |=> rd_req && (rd_addr == $past(byte_addr))
         ##1 (tx_byte == $past(rd_data)))
      else $error("read address or data slot wrong");
   AST_WRITE_INC: assert property (s_push_inc |=> (wr_ptr == AW'($past(wr_ptr) + 1'b1)))
      else $error("write address did not step by one");
   AST_FIFO_HOLD: assert property ((push && wr_ptr == FIFO_ADDR) |=> (wr_ptr == FIFO_ADDR))
      else $error("FIFO address was incremented");
   AST_DESELECT: assert property ($rose(nss_n) |=> (bit_cnt == `HISEL_RST_BITCNT)
         && (phase == hisel_pkg::HISEL_PH_IDLE) && !miso)
      else $error("deselect did not clear byte state");
   AST_WRITE_MISO: assert property ((phase == hisel_pkg::HISEL_PH_WRITE && sck_fall) |=> !miso)
      else $error("MISO carried data during a write");

endmodule // hisel_spi_slave
